/* File: logic/onv_consts.vh */
// Purpose: shared constants for the nonvolatile load and program controller.
// Assumes: 50 MHz system clock.
// Notes: unlock values, page select codes and timing counts live here.
`ifndef ONV_CONSTS_VH
`define ONV_CONSTS_VH

`define ONV_CLK_MHZ          50
`define ONV_PROG_TIME_MS     100
`define ONV_PROG_CYCLES      (`ONV_PROG_TIME_MS * 1000 * `ONV_CLK_MHZ)
`define ONV_STAB_CYCLES      16

`define ONV_UNLOCK1_0        8'h02
`define ONV_UNLOCK1_1        8'hb7
`define ONV_UNLOCK1_2        8'h78
`define ONV_UNLOCK1_3        8'hbc
`define ONV_UNLOCK2_0        8'h7e
`define ONV_UNLOCK2_1        8'h12
`define ONV_UNLOCK2_2        8'h08
`define ONV_UNLOCK2_3        8'h6f

`define ONV_GO_PAGE1         2'h1
`define ONV_GO_PAGE2         2'h3

// Page status bit positions.
`define ONV_PS_LOADED        0
`define ONV_PS_LOADWARN      1
`define ONV_PS_PAGE_LOAD_ERROR       2
`define ONV_PS_SUCCESS       3
`define ONV_PS_ATTEMPT       4
`define ONV_PS_OVERVOLTAGE_OK          5
`define ONV_PS_UNDERVOLTAGE_OK          6
`define ONV_PS_PAGE_FORMAT_ERROR        7

// Programming status bit positions.
`define ONV_PG_DONE          0
`define ONV_PG_UNLOCK        1
`define ONV_PG_PROGRAM_UNDERVOLTAGE_ERROR         2
`define ONV_PG_PROGRAM_OVERVOLTAGE_ERROR         3
`define ONV_PG_STABILITY_UNDERVOLTAGE_ERROR        4
`define ONV_PG_STABILITY_OVERVOLTAGE_ERROR        5
`define ONV_PG_SELERR        6

// Fault bit positions.
`define ONV_FT_SEC           0
`define ONV_FT_DED           1
`define ONV_FT_FACTLD        2
`define ONV_FT_CUSTLD        3
`define ONV_FT_FACTCRC       4
`define ONV_FT_CUSTCRC       5
`define ONV_FT_GBLOV         6

`endif

/* File: logic/onv_secded.v */
// Purpose: single correct, double detect decode of one stored word.
// Assumes: extended Hamming code, 8 data bits, 13 bit codeword.
// Notes: purely combinational.
`timescale 1ns/1ps
module onv_secded
(
   code_in,
   data_out,
   single_err,
   double_err
);
   input  wire [12:0] code_in;
   output reg  [7:0]  data_out;
   output reg         single_err;
   output reg         double_err;

   reg [3:0]  syn;
   reg        par;
   reg [12:0] fixed;
   integer    i;

   // Bit 0 is overall parity, bits 1..12 are Hamming positions.
   always @*
   begin
      syn = 4'h0;
      par = ^code_in;
      for (i = 1; i < 13; i = i + 1)
      begin
         if (code_in[i])
            syn = syn ^ i[3:0];
      end
      fixed = code_in;
      single_err = 1'b0;
      double_err = 1'b0;
      if (par)
      begin
         single_err = 1'b1;
         if (syn < 4'hd)
            fixed[syn] = ~code_in[syn];
      end
      else if (syn != 4'h0)
         double_err = 1'b1;
      data_out = {fixed[12:9], fixed[7:5], fixed[3]};
   end
endmodule

/* File: logic/onv_crc8.v */
// Purpose: running CRC-8 over loaded bytes.
// Assumes: polynomial x^8+x^2+x+1, seed all ones.
// Notes: clear restarts the sum, enable folds in one byte.
`timescale 1ns/1ps
module onv_crc8
(
   clk_sys,
   rst_b,
   clear,
   enable,
   data_in,
   crc
);
   input  wire       clk_sys;
   input  wire       rst_b;
   input  wire       clear;
   input  wire       enable;
   input  wire [7:0] data_in;
   output reg  [7:0] crc;

   function [7:0] step;
      input [7:0] c;
      input [7:0] d;
      reg   [7:0] r;
      integer     k;
      begin
         r = c ^ d;
         for (k = 0; k < 8; k = k + 1)
            r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
         step = r;
      end
   endfunction

   always @(posedge clk_sys)
   begin
      if (!rst_b || clear)
         crc <= 8'hff;
      else if (enable)
         crc <= step(crc, data_in);
   end
endmodule

/* File: logic/onv_ctrl.v */
// Summary of operation
// - Every reset reloads factory shadows, and customer shadows when a page is valid.
// - Apply SEC/DED, flag single and double errors.
// - Separate factory and customer load error bits.
// - Separate factory and customer checksum error bits.
// - Programming overvoltage sets global overvoltage bit.
// - Load newest valid page, page 2 first.
// - Page valid only when success bit set.
// - Mark the selected page as loaded.
// - Single error: correct, warn, record block.
// - Double error: default block, flag, record block.
// - Stage one unlock bytes 02 b7 78 bc.
// - Stage two unlock bytes 7e 12 08 6f.
// - Any break in order voids unlock.
// - Unlock sets status; next write must start.
// - Start codes 01 page 1, 03 page 2.
// - Success sets done and page success bits.
// - Voltage faults clear ok bits, set errors.
// - Failed stability test leaves attempt clear.
// - Unavailable page sets selection error.
// - Faults latch until reset; global overvoltage also until condition gone.
// - No programming start above temperature limit.
//
// Purpose: nonvolatile array load at reset and guarded page programming.
// Assumes: array read port answers in one cycle; host writes are pulses.
// Notes: programming duration is a parameter so simulation can shorten it.
`timescale 1ns/1ps
`include "onv_consts.vh"
module onv_ctrl
#(
   parameter BLOCKS     = 8,
   parameter PROG_TIME  = `ONV_PROG_CYCLES,
   parameter STAB_TIME  = `ONV_STAB_CYCLES
)
(
   clk_sys,
   rst_b,
   nvm_addr,
   nvm_code,
   nvm_factory_checksum_error,
   nvm_customer_checksum_error,
   nvm_page_flags,
   prog_uv,
   prog_ov,
   over_temp,
   unlock_wr,
   unlock_idx,
   unlock_data,
   prog_ctrl_wr,
   prog_ctrl_data,
   other_access,
   fault_rst,
   shadow_wr,
   shadow_addr,
   shadow_data,
   nvm_prog_en,
   nvm_prog_page,
   load_busy,
   fault_status,
   customer_page1_status,
   customer_page2_status,
   programming_status,
   corrected_block_location,
   uncorrectable_block_location
);
   input  wire        clk_sys;
   input  wire        rst_b;
   output reg  [7:0]  nvm_addr;
   input  wire [12:0] nvm_code;
   input  wire [7:0]  nvm_factory_checksum_error;
   input  wire [7:0]  nvm_customer_checksum_error;
   input  wire [3:0]  nvm_page_flags;
   input  wire        prog_uv;
   input  wire        prog_ov;
   input  wire        over_temp;
   input  wire        unlock_wr;
   input  wire [2:0]  unlock_idx;
   input  wire [7:0]  unlock_data;
   input  wire        prog_ctrl_wr;
   input  wire [1:0]  prog_ctrl_data;
   input  wire        other_access;
   input  wire [6:0]  fault_rst;
   output reg         shadow_wr;
   output reg  [7:0]  shadow_addr;
   output reg  [7:0]  shadow_data;
   output reg         nvm_prog_en;
   output reg         nvm_prog_page;
   output reg         load_busy;
   output reg  [6:0]  fault_status;
   output reg  [7:0]  customer_page1_status;
   output reg  [7:0]  customer_page2_status;
   output reg  [6:0]  programming_status;
   output reg  [7:0]  corrected_block_location;
   output reg  [7:0]  uncorrectable_block_location;

   localparam S_IDLE  = 3'h0;
   localparam S_FACT  = 3'h1;
   localparam S_CUST  = 3'h2;
   localparam S_CHECK = 3'h3;
   localparam S_STAB  = 3'h4;
   localparam S_PROG  = 3'h5;

   // Sync of external status pins; first stage feeds only the second.
   reg [2:0]  meta;
   reg [2:0]  sync;
   wire       uv_s   = sync[0];
   wire       ov_s   = sync[1];
   wire       temp_s = sync[2];

   reg [2:0]  state;
   reg [7:0]  blk;
   reg [31:0] timer;
   reg [2:0]  ul_pos;
   reg        space_err;
   reg        sel_page;
   reg        load_cust;
   reg        seen_uv;
   reg        seen_ov;
   wire [7:0] dec_data;
   wire       dec_sec;
   wire       dec_ded;
   wire [7:0] crc_now;
   wire       crc_clear = (state == S_IDLE) || (state == S_CHECK);

   onv_secded u_dec
   (
      .code_in    (nvm_code),
      .data_out   (dec_data),
      .single_err (dec_sec),
      .double_err (dec_ded)
   );

   onv_crc8 u_crc
   (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .clear   (crc_clear),
      .enable  (state == S_FACT || state == S_CUST),
      .data_in (dec_data),
      .crc     (crc_now)
   );

   function [7:0] unlock_byte;
      input [2:0] i;
      begin
         case (i)
            3'h0: unlock_byte = `ONV_UNLOCK1_0;
            3'h1: unlock_byte = `ONV_UNLOCK1_1;
            3'h2: unlock_byte = `ONV_UNLOCK1_2;
            3'h3: unlock_byte = `ONV_UNLOCK1_3;
            3'h4: unlock_byte = `ONV_UNLOCK2_0;
            3'h5: unlock_byte = `ONV_UNLOCK2_1;
            3'h6: unlock_byte = `ONV_UNLOCK2_2;
            default: unlock_byte = `ONV_UNLOCK2_3;
         endcase
      end
   endfunction

   // Page is writable only with attempt and format error both clear.
   function page_free;
      input [7:0] st;
      begin
         page_free = !st[`ONV_PS_ATTEMPT] && !st[`ONV_PS_PAGE_FORMAT_ERROR];
      end
   endfunction

   wire [7:0] sel_stat = prog_ctrl_data[1] ? customer_page2_status
                                           : customer_page1_status;
   wire       unlocked = programming_status[`ONV_PG_UNLOCK];
   wire       prog_ok  = !(seen_uv | seen_ov);

   always @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         meta <= 3'h0;
         sync <= 3'h0;
      end
      else
      begin
         meta <= {over_temp, prog_ov, prog_uv};
         sync <= meta;
      end
   end

   always @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         state <= S_FACT;
         blk <= 8'h00;
         timer <= 32'h0;
         ul_pos <= 3'h0;
         space_err <= 1'b0;
         sel_page <= 1'b0;
         load_cust <= 1'b0;
         seen_uv <= 1'b0;
         seen_ov <= 1'b0;
         nvm_addr <= 8'h00;
         shadow_wr <= 1'b0;
         shadow_addr <= 8'h00;
         shadow_data <= 8'h00;
         nvm_prog_en <= 1'b0;
         nvm_prog_page <= 1'b0;
         load_busy <= 1'b1;
         fault_status <= 7'h00;
         customer_page1_status <= 8'h00;
         customer_page2_status <= 8'h00;
         programming_status <= 7'h00;
         corrected_block_location <= 8'h00;
         uncorrectable_block_location <= 8'h00;
      end
      else
      begin
         shadow_wr <= 1'b0;
         // clear only when condition gone; set wins
         if (fault_rst[`ONV_FT_GBLOV] && !ov_s)
            fault_status[`ONV_FT_GBLOV] <= 1'b0;
         fault_status[5:0] <= fault_status[5:0] & ~fault_rst[5:0];
         if (fault_rst[`ONV_FT_SEC])
            corrected_block_location <= 8'h00;
         if (fault_rst[`ONV_FT_DED])
            uncorrectable_block_location <= 8'h00;

         case (state)
            S_FACT, S_CUST:
            begin
               shadow_wr <= 1'b1;
               shadow_addr <= {load_cust, blk[6:0]};
               shadow_data <= dec_data;
               if (dec_sec)
               begin
                  fault_status[`ONV_FT_SEC] <= 1'b1;
                  corrected_block_location <= blk;
                  if (load_cust && sel_page)
                     customer_page2_status[`ONV_PS_LOADWARN] <= 1'b1;
                  else if (load_cust)
                     customer_page1_status[`ONV_PS_LOADWARN] <= 1'b1;
               end
               if (dec_ded)
               begin
                  shadow_data <= 8'h00;
                  space_err <= 1'b1;
                  fault_status[`ONV_FT_DED] <= 1'b1;
                  uncorrectable_block_location <= blk;
                  if (load_cust && sel_page)
                     customer_page2_status[`ONV_PS_PAGE_LOAD_ERROR] <= 1'b1;
                  else if (load_cust)
                     customer_page1_status[`ONV_PS_PAGE_LOAD_ERROR] <= 1'b1;
               end
               if (blk == BLOCKS - 1)
                  state <= S_CHECK;
               else
               begin
                  blk <= blk + 8'h01;
                  nvm_addr <= {load_cust, sel_page, blk[5:0] + 6'h01};
               end
            end
            S_CHECK:
            begin
               blk <= 8'h00;
               space_err <= 1'b0;
               if (!load_cust)
               begin
                  if (space_err)
                     fault_status[`ONV_FT_FACTLD] <= 1'b1;
                  if (crc_now != nvm_factory_checksum_error)
                     fault_status[`ONV_FT_FACTCRC] <= 1'b1;
                  customer_page1_status[`ONV_PS_SUCCESS] <= nvm_page_flags[0];
                  customer_page1_status[`ONV_PS_ATTEMPT] <= nvm_page_flags[1];
                  customer_page2_status[`ONV_PS_SUCCESS] <= nvm_page_flags[2];
                  customer_page2_status[`ONV_PS_ATTEMPT] <= nvm_page_flags[3];
                  // page 2 first, only if success bit set
                  if (nvm_page_flags[2] || nvm_page_flags[0])
                  begin
                     load_cust <= 1'b1;
                     sel_page <= nvm_page_flags[2];
                     nvm_addr <= {2'b11 & {1'b1, nvm_page_flags[2]}, 6'h00};
                     if (nvm_page_flags[2])
                        customer_page2_status[`ONV_PS_LOADED] <= 1'b1;
                     else
                        customer_page1_status[`ONV_PS_LOADED] <= 1'b1;
                     state <= S_CUST;
                  end
                  else
                  begin
                     state <= S_IDLE;
                     load_busy <= 1'b0;
                  end
               end
               else
               begin
                  if (space_err)
                     fault_status[`ONV_FT_CUSTLD] <= 1'b1;
                  if (crc_now != nvm_customer_checksum_error)
                     fault_status[`ONV_FT_CUSTCRC] <= 1'b1;
                  state <= S_IDLE;
                  load_busy <= 1'b0;
               end
            end
            S_IDLE:
            begin
               if (unlock_wr)
               begin
                  if (!unlocked && unlock_idx == ul_pos
                      && unlock_data == unlock_byte(ul_pos))
                  begin
                     ul_pos <= ul_pos + 3'h1;
                     if (ul_pos == 3'h7)
                        programming_status[`ONV_PG_UNLOCK] <= 1'b1;
                  end
                  else
                  begin
                     ul_pos <= 3'h0;
                     programming_status[`ONV_PG_UNLOCK] <= 1'b0;
                  end
               end
               else if (other_access && !unlocked)
                  ul_pos <= 3'h0;
               else if (prog_ctrl_wr)
               begin
                  ul_pos <= 3'h0;
                  programming_status <= 7'h00;
                  if (unlocked && !temp_s
                      && (prog_ctrl_data == `ONV_GO_PAGE1
                          || prog_ctrl_data == `ONV_GO_PAGE2))
                  begin
                     if (page_free(sel_stat))
                     begin
                        sel_page <= prog_ctrl_data[1];
                        seen_uv <= 1'b0;
                        seen_ov <= 1'b0;
                        timer <= 32'h0;
                        state <= S_STAB;
                     end
                     else
                        programming_status[`ONV_PG_SELERR] <= 1'b1;
                  end
               end
            end
            S_STAB:
            begin
               timer <= timer + 32'h1;
               seen_uv <= seen_uv | uv_s;
               seen_ov <= seen_ov | ov_s;
               if (timer == STAB_TIME - 1)
               begin
                  timer <= 32'h0;
                  if (seen_uv || seen_ov || uv_s || ov_s)
                  begin
                     programming_status[`ONV_PG_STABILITY_UNDERVOLTAGE_ERROR] <= seen_uv | uv_s;
                     programming_status[`ONV_PG_STABILITY_OVERVOLTAGE_ERROR] <= seen_ov | ov_s;
                     state <= S_IDLE;
                  end
                  else
                  begin
                     nvm_prog_en <= 1'b1;
                     nvm_prog_page <= sel_page;
                     state <= S_PROG;
                  end
               end
            end
            S_PROG:
            begin
               timer <= timer + 32'h1;
               seen_uv <= seen_uv | uv_s;
               seen_ov <= seen_ov | ov_s;
               if (ov_s)
                  fault_status[`ONV_FT_GBLOV] <= 1'b1;
               if (timer == PROG_TIME - 1)
               begin
                  nvm_prog_en <= 1'b0;
                  state <= S_IDLE;
                  programming_status[`ONV_PG_DONE] <= prog_ok;
                  programming_status[`ONV_PG_PROGRAM_UNDERVOLTAGE_ERROR] <= seen_uv;
                  programming_status[`ONV_PG_PROGRAM_OVERVOLTAGE_ERROR] <= seen_ov;
                  if (sel_page)
                  begin
                     customer_page2_status[`ONV_PS_ATTEMPT] <= 1'b1;
                     customer_page2_status[`ONV_PS_SUCCESS] <= prog_ok;
                     customer_page2_status[`ONV_PS_OVERVOLTAGE_OK] <= !seen_ov;
                     customer_page2_status[`ONV_PS_UNDERVOLTAGE_OK] <= !seen_uv;
                  end
                  else
                  begin
                     customer_page1_status[`ONV_PS_ATTEMPT] <= 1'b1;
                     customer_page1_status[`ONV_PS_SUCCESS] <= prog_ok;
                     customer_page1_status[`ONV_PS_OVERVOLTAGE_OK] <= !seen_ov;
                     customer_page1_status[`ONV_PS_UNDERVOLTAGE_OK] <= !seen_uv;
                  end
               end
            end
            default:
               state <= S_IDLE;
         endcase
      end
   end
endmodule

/* File: dv/onv_nvm_model.sv */
// Purpose: behavioural nonvolatile array that answers the controller.
// Assumes: combinational read, extended Hamming words, CRC-8 poly 07.
// Notes: an error address of 8'hff injects nothing.
`timescale 1ns/1ps
module onv_nvm_model
#(
   parameter BLOCKS = 8
)
(
   input  wire  [7:0]  nvm_addr,
   input  wire  [3:0]  page_flags,
   input  wire  [7:0]  sec_addr,
   input  wire  [7:0]  ded_addr,
   input  wire         crc_bad,
   output logic [12:0] nvm_code,
   output logic [7:0]  factory_checksum_error,
   output logic [7:0]  customer_checksum_error
);
   function automatic [12:0] enc(input [7:0] d);
      logic [12:0] c;
      c = {d[7:4], 1'b0, d[3:1], 1'b0, d[0], 3'b000};
      c[1] = c[3] ^ c[5] ^ c[7] ^ c[9] ^ c[11];
      c[2] = c[3] ^ c[6] ^ c[7] ^ c[10] ^ c[11];
      c[4] = c[5] ^ c[6] ^ c[7] ^ c[12];
      c[8] = c[9] ^ c[10] ^ c[11] ^ c[12];
      c[0] = ^c[12:1];
      return c;
   endfunction

   function automatic [7:0] crc_step(input [7:0] c, input [7:0] d);
      c = c ^ d;
      for (int b = 0; b < 8; b++)
         c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
      return c;
   endfunction

   always @*
   begin
      nvm_code = enc(nvm_addr ^ 8'ha5);
      if (nvm_addr == sec_addr)
         nvm_code[6] = ~nvm_code[6];
      if (nvm_addr == ded_addr)
         nvm_code = nvm_code ^ 13'h0240;
      factory_checksum_error = 8'hff;
      customer_checksum_error = 8'hff;
      // sums over the page that will load
      for (int i = 0; i < BLOCKS; i++)
      begin
         factory_checksum_error = crc_step(factory_checksum_error, 8'(i) ^ 8'ha5);
         customer_checksum_error = crc_step(customer_checksum_error,
                             {1'b1, page_flags[2], 6'(i)} ^ 8'ha5);
      end
      if (crc_bad)
         customer_checksum_error = ~customer_checksum_error;
   end
endmodule

/* File: dv/onv_ctrl_sva.sv */
// Purpose: port-level properties of the load and program controller.
// Assumes: one clock, synchronous active-low reset.
// Notes: PROG_TIME follows the instance it is bound to.
`timescale 1ns/1ps
module onv_ctrl_sva
#(
   parameter PROG_TIME = 20
)
(
   input wire       clk_sys,
   input wire       rst_b,
   input wire [3:0] nvm_page_flags,
   input wire       over_temp,
   input wire       unlock_wr,
   input wire [2:0] unlock_idx,
   input wire [7:0] unlock_data,
   input wire       prog_ctrl_wr,
   input wire [1:0] prog_ctrl_data,
   input wire [6:0] fault_rst,
   input wire       nvm_prog_en,
   input wire       load_busy,
   input wire [6:0] fault_status,
   input wire [7:0] customer_page1_status,
   input wire [7:0] customer_page2_status,
   input wire [6:0] programming_status
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   logic [31:0] high_cnt;

   always @(posedge clk_sys)
      if (!rst_b || !nvm_prog_en)
         high_cnt <= 32'h0;
      else
         high_cnt <= high_cnt + 32'h1;

   property p_busy_on_release; $rose(rst_b) |-> load_busy; endproperty
   a_busy_on_release: assert property (p_busy_on_release)
      else $error("load not pending after reset");
   property p_no_prog_load; load_busy |-> !nvm_prog_en; endproperty
   a_no_prog_load: assert property (p_no_prog_load)
      else $error("programming during load");
   property p_prog_len; nvm_prog_en |-> high_cnt < PROG_TIME; endproperty
   a_prog_len: assert property (p_prog_len)
      else $error("programming runs too long");
   property p_unlock_rise;
      $rose(programming_status[1]) |-> $past(unlock_wr)
         && $past(unlock_idx) == 3'h7 && $past(unlock_data) == 8'h6f;
   endproperty
   a_unlock_rise: assert property (p_unlock_rise)
      else $error("unlock without final key write");
   property p_start_drops;
      prog_ctrl_wr && !load_busy && programming_status[1]
         |=> !programming_status[1];
   endproperty
   a_start_drops: assert property (p_start_drops)
      else $error("unlock kept after start");
   property p_cool_start; $rose(nvm_prog_en) |-> !over_temp; endproperty
   a_cool_start: assert property (p_cool_start)
      else $error("programming started while hot");
   property p_page2_first;
      $fell(load_busy) && nvm_page_flags[2]
         |-> ##[0:2] customer_page2_status[0];
   endproperty
   a_page2_first: assert property (p_page2_first)
      else $error("valid page 2 not loaded");
   property p_invalid_page;
      $fell(load_busy) && !nvm_page_flags[0]
         |-> !customer_page1_status[0] [*3];
   endproperty
   a_invalid_page: assert property (p_invalid_page)
      else $error("invalid page 1 loaded");
   property p_sel_err;
      prog_ctrl_wr && !load_busy && programming_status[1] && !over_temp
         && prog_ctrl_data == 2'h1 && customer_page1_status[4]
         |-> ##[1:2] programming_status[6];
   endproperty
   a_sel_err: assert property (p_sel_err)
      else $error("used page accepted");
   property p_fault_latch; $fell(fault_status[1]) |-> $past(fault_rst[1]);
   endproperty
   a_fault_latch: assert property (p_fault_latch)
      else $error("double error flag cleared by itself");

   c_prog_end: cover property ($fell(nvm_prog_en));
   c_unlock: cover property ($rose(programming_status[1]));
   c_sel_err: cover property ($rose(programming_status[6]));
endmodule

bind onv_ctrl onv_ctrl_sva #(.PROG_TIME(PROG_TIME)) u_sva (.*);

/* File: dv/testbench.sv */
// Purpose: self-checking bench for the load and program controller.
// Assumes: 50 MHz clock, programming time shortened to 20 cycles.
// Notes: shadow writes are matched against a queue of expected bytes.
`timescale 1ns/1ps
module testbench;
   logic        clk_sys, rst_b, prog_uv, prog_ov, over_temp, crc_bad;
   logic        unlock_wr, prog_ctrl_wr, other_access, mon_on;
   logic [2:0]  unlock_idx;
   logic [7:0]  unlock_data, sec_addr, ded_addr;
   logic [1:0]  prog_ctrl_data;
   logic [6:0]  fault_rst;
   logic [3:0]  nvm_page_flags;
   wire  [7:0]  nvm_addr, fcrc, ccrc, shadow_addr, shadow_data, ps1, ps2;
   wire  [7:0]  sec_loc, ded_loc;
   wire  [12:0] nvm_code;
   wire         shadow_wr, nvm_prog_en, nvm_prog_page, load_busy;
   wire  [6:0]  fault_status, pstat;
   logic [15:0] exp_q[$];
   logic [7:0]  key[8] = '{8'h02, 8'hb7, 8'h78, 8'hbc,
                          8'h7e, 8'h12, 8'h08, 8'h6f};
   int          fail_count = 0;
   int          checks = 0;
   int          cycles = 0;

   onv_ctrl #(.PROG_TIME(20)) dut (.*, .nvm_factory_checksum_error(fcrc),
      .nvm_customer_checksum_error(ccrc), .customer_page1_status(ps1),
      .customer_page2_status(ps2), .programming_status(pstat),
      .corrected_block_location(sec_loc),
      .uncorrectable_block_location(ded_loc));

   onv_nvm_model u_nvm (.*, .page_flags(nvm_page_flags),
      .factory_checksum_error(fcrc), .customer_checksum_error(ccrc));

   initial
   begin
      clk_sys = 0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic print_verdict;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h",
                  $time, seen, exp);
      end
   endtask

   // A whole run is a few hundred cycles; this ceiling means a hang.
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         print_verdict;
      end
   end

   always @(posedge clk_sys)
      if (mon_on && shadow_wr === 1'b1)
         chk({shadow_addr, shadow_data},
             exp_q.size() ? exp_q.pop_front() : 17'h10000);

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask

   task automatic expect_load(input logic [7:0] base, input logic [7:0] ded);
      logic [7:0] a;
      for (int i = 0; i < 16; i++)
      begin
         a = (i < 8) ? 8'(i) : base + 8'(i - 8);
         exp_q.push_back({(i < 8) ? 8'(i) : (8'h80 | 8'(i - 8)),
                          (a == ded) ? 8'h00 : (a ^ 8'ha5)});
      end
   endtask

   task automatic do_reset(input logic [3:0] flags, input int n);
      tick(1);
      rst_b = 0;
      nvm_page_flags = flags;
      tick(n);
      rst_b = 1;
      for (int k = 0; k < 400 && load_busy !== 1'b0; k++)
         tick(1);
      chk(load_busy, 0);
      tick(3);
      if (mon_on)
         chk(exp_q.size(), 0);
   endtask

   task automatic unlock(input int bad);
      for (int i = 0; i < 8; i++)
      begin
         tick(1);
         unlock_wr = 1;
         unlock_idx = 3'(i);
         unlock_data = key[i];
         if (i == bad)
            unlock_data ^= 8'($urandom_range(1, 255));
      end
      tick(1);
      unlock_wr = 0;
      tick(1);
   endtask

   task automatic pulse(input logic [1:0] code, input logic acc,
                        input logic [6:0] rst);
      tick(1);
      prog_ctrl_wr = (code != 2'h0);
      prog_ctrl_data = code;
      other_access = acc;
      fault_rst = rst;
      tick(1);
      prog_ctrl_wr = 0;
      other_access = 0;
      fault_rst = 0;
   endtask

   task automatic wait_en(input logic lvl);
      for (int k = 0; k < 60 && nvm_prog_en !== lvl; k++)
         tick(1);
   endtask

   initial
   begin
      {rst_b, prog_uv, prog_ov, over_temp, crc_bad, unlock_wr} = 0;
      {prog_ctrl_wr, other_access, unlock_idx, unlock_data} = 0;
      {prog_ctrl_data, fault_rst, nvm_page_flags} = 0;
      sec_addr = 8'hff;
      ded_addr = 8'hff;
      mon_on = 1;
      void'($urandom(32'h8446b82f));
      expect_load(8'hc0, 8'hff);
      do_reset(4'b0101, 16);
      chk(fault_status, 0);
      chk({ps2[0], ps1[0]}, 2'b10);
      expect_load(8'h80, 8'hff);
      crc_bad = 1;
      do_reset(4'b0001, 2);
      chk(fault_status, 7'h20);
      chk(ps1[0], 1);
      crc_bad = 0;
      sec_addr = 8'hc3;
      ded_addr = 8'hc5;
      expect_load(8'hc0, 8'hc5);
      do_reset(4'b0100, 2);
      chk(fault_status & 7'h5f, 7'h0b);
      chk(ps2[2:0], 3'b111);
      chk({sec_loc, ded_loc}, 16'h0305);
      pulse(2'h0, 0, 7'h01);
      chk(fault_status[1:0], 2'b10);
      {sec_addr, ded_addr, mon_on} = {8'hff, 8'hff, 1'b0};
      do_reset(4'b0000, 2);
      chk({ps1[0], ps2[0]}, 0);
      // page 1 is spent, page 2 is fresh from here on.
      do_reset(4'b0011, 2);
      unlock($urandom_range(0, 7));
      chk(pstat[1], 0);
      unlock(8);
      chk(pstat[1], 1);
      pulse(2'h0, 1, 7'h00);
      chk(pstat[1], 1);
      pulse(2'h1, 0, 7'h00);
      tick(3);
      chk({pstat[6], pstat[1], nvm_prog_en}, 3'b100);
      over_temp = 1;
      unlock(8);
      pulse(2'h3, 0, 7'h00);
      tick(60);
      chk({nvm_prog_en, pstat[0], ps2[4]}, 0);
      {over_temp, prog_uv} = 2'b01;
      unlock(8);
      pulse(2'h3, 0, 7'h00);
      tick(60);
      chk({pstat[4], ps2[4], nvm_prog_en}, 3'b100);
      prog_uv = 0;
      do_reset(4'b0011, 2);
      unlock(8);
      pulse(2'h3, 0, 7'h00);
      wait_en(1);
      chk(nvm_prog_page, 1);
      tick(60);
      chk(pstat, 7'h01);
      chk(ps2[6:3], 4'hf);
      do_reset(4'b0011, 2);
      unlock(8);
      pulse(2'h3, 0, 7'h00);
      wait_en(1);
      prog_ov = 1;
      wait_en(0);
      tick(4);
      chk({pstat[3], fault_status[6], ps2[5]}, 3'b110);
      pulse(2'h0, 0, 7'h40);
      chk(fault_status[6], 1);
      prog_ov = 0;
      tick(4);
      pulse(2'h0, 0, 7'h40);
      chk(fault_status[6], 0);
      print_verdict;
   end
endmodule
